/* core/ssop_defines.svh */
`ifndef SSOP_DEFINES_SVH
`define SSOP_DEFINES_SVH
// ----------------------------------------
// Data word and lanes
// ----------------------------------------
`define SSOP_WORD_BITS 22
`define SSOP_LANES     4
// ----------------------------------------
// Output control code fields
// ----------------------------------------
`define SSOP_MODE_HI   1
`define SSOP_MODE_LO   0
`define SSOP_WID_HI    3
`define SSOP_WID_LO    2
`define SSOP_RATE_BIT  4
`define SSOP_SEL_HI    7
`define SSOP_SEL_LO    6
`define SSOP_MODE_SRC  2'h3
`define SSOP_WID_DUAL  2'h2
`define SSOP_WID_QUAD  2'h3
`define SSOP_N_ONE     3'h1
`define SSOP_N_TWO     3'h2
`define SSOP_N_FOUR    3'h4
`define SSOP_CFG_RST   8'h00
// Internal clock half periods in hclk cycles
`define SSOP_HALF_INT  4'h1
`define SSOP_HALF_IB2  4'h2
`define SSOP_HALF_IB4  4'h4
// Output clocks of an optimal read frame
`define SSOP_NCLK_STD  5'h09
`define SSOP_NCLK_QS   5'h05
`define SSOP_NCLK_DD   5'h05
`define SSOP_NCLK_QD   5'h03
// ----------------------------------------
// Controller registers
// ----------------------------------------
`define SSOP_A_CTRL    8'h00
`define SSOP_A_DEVCFG  8'h04
`define SSOP_A_DIV     8'h08
`define SSOP_A_STAT    8'h0C
`define SSOP_A_DATA    8'h10
`define SSOP_CTRL_GO   0
`define SSOP_CTRL_AUTO 1
`define SSOP_CTRL_RST  2
`define SSOP_DIV_RST   8'h02
`define SSOP_HTRANS_ACT 1
// ----------------------------------------
// Timing
// ----------------------------------------
`define SSOP_CLK_NS    40
`define SSOP_CONVH_NS  40
`define SSOP_CONV_NS   1000
`endif

/* core/ssop_pkg.sv */
`include "ssop_defines.svh"
package ssop_pkg;
    typedef enum logic [1:0] {CLK_EXT, CLK_INT, CLK_IB2, CLK_IB4} ssop_clk_src_type;
    typedef enum logic [2:0] {H_IDLE, H_CONV, H_WAIT, H_SEL, H_XFER, H_PUSH} ssop_host_state_type;

    function automatic logic is_src(input logic [7:0] c);
        is_src = (c[`SSOP_MODE_HI:`SSOP_MODE_LO] == `SSOP_MODE_SRC);
    endfunction

    function automatic logic is_ddr(input logic [7:0] c);
        is_ddr = c[`SSOP_RATE_BIT];
    endfunction

    function automatic logic [2:0] lane_count(input logic [7:0] c);
        unique case (c[`SSOP_WID_HI:`SSOP_WID_LO])
            `SSOP_WID_DUAL: lane_count = `SSOP_N_TWO;
            `SSOP_WID_QUAD: lane_count = `SSOP_N_FOUR;
            default:        lane_count = `SSOP_N_ONE;
        endcase
    endfunction

    function automatic ssop_clk_src_type clk_src(input logic [7:0] c);
        clk_src = ssop_clk_src_type'(c[`SSOP_SEL_HI:`SSOP_SEL_LO]);
    endfunction

    function automatic logic [4:0] opt_clocks(input logic [7:0] c);
        opt_clocks = `SSOP_NCLK_STD;
        if (lane_count(c) == `SSOP_N_FOUR)
            opt_clocks = is_ddr(c) ? `SSOP_NCLK_QD : `SSOP_NCLK_QS;
        else if (lane_count(c) == `SSOP_N_TWO && is_ddr(c))
            opt_clocks = `SSOP_NCLK_DD;
    endfunction
endpackage

/* core/ssop_link_if.sv */
`timescale 1ns/100ps
interface ssop_link_if;
    logic       cs_n;
    logic       sclk;
    logic       conv_start;
    logic       reset_n;
    logic       cfg_wr;
    logic [7:0] cfg_out_ctrl;
    logic [7:0] cfg_in_proto;
    logic       ready_clock_out;
    logic [3:0] serial_out_lane;

    modport device (
        input  cs_n, sclk, conv_start, reset_n, cfg_wr, cfg_out_ctrl, cfg_in_proto,
        output ready_clock_out, serial_out_lane
    );
    modport host (
        output cs_n, sclk, conv_start, reset_n, cfg_wr, cfg_out_ctrl, cfg_in_proto,
        input  ready_clock_out, serial_out_lane
    );
endinterface

/* core/ssop_fifo.sv */
`timescale 1ns/100ps
module ssop_fifo #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 32,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [AW:0]           count
);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r;
    logic [AW-1:0]    rp_r;
    logic [AW:0]      cnt_r;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign count     = cnt_r;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge hclk) begin
        if (push)
            mem_r[wp_r] <= in_data;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            if (push)
                wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
            if (pop)
                rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
            if (push && !pop)
                cnt_r <= cnt_r + 1'b1;
            else if (pop && !push)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // ssop_fifo

/* core/ssop_host.sv */
// Implementation choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "ssop_defines.svh"
module ssop_host #(
    parameter int WORD_BITS   = `SSOP_WORD_BITS,
    parameter int DEPTH       = 32,
    parameter int CONV_CYCLES = (`SSOP_CONV_NS + `SSOP_CLK_NS - 1) / `SSOP_CLK_NS
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    ssop_link_if.host        link
);
    localparam int CONVH_CYC = (`SSOP_CONVH_NS + `SSOP_CLK_NS - 1) / `SSOP_CLK_NS;
    localparam int AW = $clog2(DEPTH);

    ssop_pkg::ssop_host_state_type st_r;
    logic [31:0] hrdata_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        go_r, auto_r, devrst_r, cfg_pend_r, cfg_wr_r;
    logic [7:0]  octl_r, iprot_r, div_r, dcnt_r;
    logic        cs_n_r, sclk_r, conv_r, rvs_q_r;
    logic [11:0] cnt_r;
    logic [4:0]  clk_cnt_r, got_r;
    logic [WORD_BITS-1:0] acc_r;
    logic        accept, wr_ctrl, wr_cfg, pop, in_ready, out_valid, ext, edge_seen, done;
    logic [WORD_BITS-1:0] out_data;
    logic [AW:0] fcount;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // Bus slave, zero wait states
    // ----------------------------------------
    assign accept  = hsel && htrans[`SSOP_HTRANS_ACT] && hready;
    assign pop     = accept && !hwrite && (haddr[7:0] == `SSOP_A_DATA);
    assign wr_ctrl = wr_pend_r && (wr_addr_r == `SSOP_A_CTRL);
    assign wr_cfg  = wr_pend_r && (wr_addr_r == `SSOP_A_DEVCFG);

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (haddr[7:0])
            `SSOP_A_CTRL:   rd_mux = {29'h0, devrst_r, auto_r, go_r};
            `SSOP_A_DEVCFG: rd_mux = {16'h0, iprot_r, octl_r};
            `SSOP_A_DIV:    rd_mux = {24'h0, div_r};
            `SSOP_A_STAT:   rd_mux = {16'h0, 8'(fcount), 4'h0, cfg_pend_r, !in_ready,
                                      !out_valid, st_r != ssop_pkg::H_IDLE};
            `SSOP_A_DATA:   rd_mux = out_valid ? 32'(out_data) : 32'h00000000;
            default:        rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h00000000;
        end else begin
            wr_pend_r <= accept && hwrite;
            if (accept)
                wr_addr_r <= haddr[7:0];
            if (accept && !hwrite)
                hrdata_r <= rd_mux;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            auto_r   <= 1'b0;
            devrst_r <= 1'b0;
            div_r    <= `SSOP_DIV_RST;
            octl_r   <= `SSOP_CFG_RST;
            iprot_r  <= `SSOP_CFG_RST;
        end else begin
            if (wr_ctrl) begin
                auto_r   <= hwdata[`SSOP_CTRL_AUTO];
                devrst_r <= hwdata[`SSOP_CTRL_RST];
            end
            if (wr_pend_r && wr_addr_r == `SSOP_A_DIV)
                div_r <= (hwdata[7:0] == 8'h00) ? 8'h01 : hwdata[7:0];
            if (wr_cfg) begin
                octl_r  <= hwdata[7:0];
                iprot_r <= hwdata[15:8];
            end
        end
    end

    // Config reaches the device only between frames
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_pend_r <= 1'b0;
            cfg_wr_r   <= 1'b0;
        end else begin
            cfg_wr_r <= cfg_pend_r && st_r == ssop_pkg::H_IDLE;
            if (wr_cfg)
                cfg_pend_r <= 1'b1;
            else if (st_r == ssop_pkg::H_IDLE)
                cfg_pend_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // Frame sequencer
    // ----------------------------------------
    assign ext       = ssop_pkg::clk_src(octl_r) == ssop_pkg::CLK_EXT;
    assign edge_seen = (link.ready_clock_out && !rvs_q_r)
                    || (!link.ready_clock_out && rvs_q_r && ssop_pkg::is_ddr(octl_r));
    // Frame ends once the word is in and, on the external clock, the optimal clock count was given
    assign done = (got_r == 5'(WORD_BITS)) &&
                  (!ext || (clk_cnt_r >= ssop_pkg::opt_clocks(octl_r) && !sclk_r));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r      <= ssop_pkg::H_IDLE;
            go_r      <= 1'b0;
            cs_n_r    <= 1'b1;
            sclk_r    <= 1'b0;
            conv_r    <= 1'b0;
            rvs_q_r   <= 1'b0;
            cnt_r     <= 12'h000;
            dcnt_r    <= 8'h00;
            clk_cnt_r <= 5'h00;
            got_r     <= 5'h00;
            acc_r     <= '0;
        end else begin
            rvs_q_r <= link.ready_clock_out;
            unique case (st_r)
                ssop_pkg::H_IDLE: begin
                    // No frame without room for its word
                    if ((go_r || auto_r) && in_ready && !cfg_pend_r && !devrst_r) begin
                        go_r   <= 1'b0;
                        conv_r <= 1'b1;
                        cnt_r  <= 12'(CONVH_CYC - 1);
                        st_r   <= ssop_pkg::H_CONV;
                    end
                end
                ssop_pkg::H_CONV: begin
                    if (cnt_r == 12'h000) begin
                        conv_r <= 1'b0;
                        cnt_r  <= 12'(CONV_CYCLES - 1);
                        st_r   <= ssop_pkg::H_WAIT;
                    end else
                        cnt_r <= cnt_r - 12'h001;
                end
                ssop_pkg::H_WAIT: begin
                    if (cnt_r == 12'h000) begin
                        cs_n_r <= 1'b0;
                        st_r   <= ssop_pkg::H_SEL;
                    end else
                        cnt_r <= cnt_r - 12'h001;
                end
                ssop_pkg::H_SEL: begin
                    dcnt_r    <= 8'h00;
                    clk_cnt_r <= 5'h00;
                    got_r     <= 5'h00;
                    acc_r     <= '0;
                    st_r      <= ssop_pkg::H_XFER;
                end
                ssop_pkg::H_XFER: begin
                    if (edge_seen)
                        for (int i = 0; i < `SSOP_LANES; i++)
                            if (i < ssop_pkg::lane_count(octl_r) && 32'(got_r) + i < WORD_BITS)
                                acc_r[WORD_BITS-1-(32'(got_r)+i)] <= link.serial_out_lane[i];
                    if (edge_seen)
                        got_r <= ((32'(got_r) + 32'(ssop_pkg::lane_count(octl_r))) > WORD_BITS)
                               ? 5'(WORD_BITS) : got_r + 5'(ssop_pkg::lane_count(octl_r));
                    if (done) begin
                        cs_n_r <= 1'b1;
                        st_r   <= ssop_pkg::H_PUSH;
                    end else if (ext) begin
                        if (dcnt_r == div_r - 8'h01) begin
                            dcnt_r <= 8'h00;
                            sclk_r <= !sclk_r;
                            if (sclk_r && clk_cnt_r != 5'h1F)
                                clk_cnt_r <= clk_cnt_r + 5'h01;
                        end else
                            dcnt_r <= dcnt_r + 8'h01;
                    end
                end
                ssop_pkg::H_PUSH: begin
                    if (in_ready)
                        st_r <= ssop_pkg::H_IDLE;
                end
            endcase
            if (wr_ctrl && hwdata[`SSOP_CTRL_GO])
                go_r <= 1'b1;
        end
    end

    ssop_fifo #(.WIDTH(WORD_BITS), .DEPTH(DEPTH)) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (st_r == ssop_pkg::H_PUSH),
        .in_ready  (in_ready),
        .in_data   (acc_r),
        .out_valid (out_valid),
        .out_ready (pop),
        .out_data  (out_data),
        .count     (fcount)
    );

    assign hrdata            = hrdata_r;
    assign hreadyout         = 1'b1;
    assign hresp             = 1'b0;
    assign link.cs_n         = cs_n_r;
    assign link.sclk         = sclk_r;
    assign link.conv_start   = conv_r;
    assign link.reset_n      = !devrst_r;
    assign link.cfg_wr       = cfg_wr_r;
    assign link.cfg_out_ctrl = octl_r;
    assign link.cfg_in_proto = iprot_r;
endmodule // ssop_host

/* core/ssop_device.sv */
`timescale 1ns/100ps
`include "ssop_defines.svh"
module ssop_device #(
    parameter int WORD_BITS = `SSOP_WORD_BITS
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    ssop_link_if.device               link,
    input  wire logic [WORD_BITS-1:0] sample_data,
    output logic                      sample_taken,
    output logic                      frame_active,
    output logic [7:0]                output_control,
    output logic [7:0]                input_protocol
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0]           octl_r;
    logic [7:0]           iprot_r;
    logic [WORD_BITS-1:0] word_r;
    logic [WORD_BITS-1:0] sr_r;
    logic                 frame_r;
    logic                 sclk_q_r;
    logic                 conv_q_r;
    logic                 int_ph_r;
    logic                 rvs_r;
    logic                 taken_r;
    logic [3:0]           div_r;
    logic [3:0]           lanes_r;
    logic                 rst_n;
    logic                 src;
    logic                 ddr;
    logic                 ext;
    logic                 start;
    logic                 rise;
    logic                 fall;
    logic                 launch;
    logic                 int_tick;
    logic [2:0]           nl;
    logic [3:0]           half;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] lane_bits(
        input logic [WORD_BITS-1:0] s,
        input logic [2:0]           n
    );
        lane_bits = 4'h0;
        for (int i = 0; i < `SSOP_LANES; i++) begin
            if (i < n)
                lane_bits[i] = s[WORD_BITS-1-i];
        end
    endfunction

    function automatic logic [3:0] int_half(input logic [7:0] c);
        unique case (ssop_pkg::clk_src(c))
            ssop_pkg::CLK_IB2: int_half = `SSOP_HALF_IB2;
            ssop_pkg::CLK_IB4: int_half = `SSOP_HALF_IB4;
            default:           int_half = `SSOP_HALF_INT;
        endcase
    endfunction

    // ----------------------------------------
    // Reset
    // ----------------------------------------
    // Pin reset is tied high in the minimum-pin setup
    assign rst_n = hresetn && link.reset_n;

    // ----------------------------------------
    // Configuration
    // ----------------------------------------
    // Writes mid-frame are dropped so the mode cannot change under a word
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            octl_r  <= `SSOP_CFG_RST;
            iprot_r <= `SSOP_CFG_RST;
        end else if (link.cfg_wr && link.cs_n && !frame_r) begin
            octl_r  <= link.cfg_out_ctrl;
            iprot_r <= link.cfg_in_proto;
        end
    end

    assign src  = ssop_pkg::is_src(octl_r);
    assign ddr  = ssop_pkg::is_ddr(octl_r);
    assign nl   = ssop_pkg::lane_count(octl_r);
    assign half = int_half(octl_r);
    // Legacy codes always run from the serial clock
    assign ext  = !src || ssop_pkg::clk_src(octl_r) == ssop_pkg::CLK_EXT;

    // ----------------------------------------
    // Conversion start
    // ----------------------------------------
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            conv_q_r <= 1'b0;
            taken_r  <= 1'b0;
            word_r   <= '0;
        end else begin
            conv_q_r <= link.conv_start;
            taken_r  <= link.conv_start && !conv_q_r;
            if (link.conv_start && !conv_q_r)
                word_r <= sample_data;
        end
    end

    // ----------------------------------------
    // Frame tracking
    // ----------------------------------------
    assign start = !link.cs_n && !frame_r;

    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n)
            frame_r <= 1'b0;
        else
            frame_r <= !link.cs_n;
    end

    // ----------------------------------------
    // Clock sources
    // ----------------------------------------
    // Internal clock is hclk over two; slower picks stretch the half period
    assign int_tick = frame_r && !link.cs_n && (div_r == half - 4'h1);

    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n) begin
            div_r    <= 4'h0;
            int_ph_r <= 1'b0;
        end else if (start || !frame_r || link.cs_n) begin
            div_r    <= 4'h0;
            int_ph_r <= 1'b0;
        end else if (int_tick) begin
            div_r    <= 4'h0;
            int_ph_r <= !int_ph_r;
        end else begin
            div_r <= div_r + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n)
            sclk_q_r <= 1'b0;
        else
            sclk_q_r <= link.sclk;
    end

    assign rise = ext ? (link.sclk && !sclk_q_r) : (int_tick && !int_ph_r);
    assign fall = ext ? (!link.sclk && sclk_q_r) : (int_tick && int_ph_r);

    // Falling-edge launches only at double rate, after the first rising one
    assign launch = frame_r && !link.cs_n
                 && (rise || (fall && ddr && src));

    // ----------------------------------------
    // Output clock
    // ----------------------------------------
    // Stays low outside frames and in the legacy protocols
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n)
            rvs_r <= 1'b0;
        else if (!frame_r || link.cs_n || !src)
            rvs_r <= 1'b0;
        else if (rise)
            rvs_r <= 1'b1;
        else if (fall)
            rvs_r <= 1'b0;
    end

    // ----------------------------------------
    // Data shifter
    // ----------------------------------------
    // Zero fill behind the word; no chaining in these modes
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n)
            sr_r <= '0;
        else if (start)
            sr_r <= word_r;
        else if (launch)
            sr_r <= sr_r << nl;
    end

    // Lanes change in the same cycle as the clock edge they belong to
    always_ff @(posedge hclk or negedge rst_n) begin
        if (!rst_n)
            lanes_r <= 4'h0;
        else if (!frame_r || link.cs_n)
            lanes_r <= 4'h0;
        else if (launch)
            lanes_r <= lane_bits(sr_r, nl);
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign link.ready_clock_out = rvs_r;
    assign link.serial_out_lane = lanes_r;
    assign sample_taken         = taken_r;
    assign frame_active         = frame_r;
    assign output_control       = octl_r;
    assign input_protocol       = iprot_r;
endmodule // ssop_device

/* tb/ssop_link_properties.sv */
`timescale 1ns/100ps
// ----
// Link checks
// ----
module ssop_link_properties (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       cs_n,
    input wire logic       sclk,
    input wire logic       reset_n,
    input wire logic       cfg_wr,
    input wire logic [7:0] cfg_out_ctrl,
    input wire logic       ready_clock_out,
    input wire logic [3:0] serial_out_lane
);
    logic [7:0] cfg_r;
    logic [4:0] hi_r;
    logic [4:0] rise_r;
    logic [4:0] half;
    logic [4:0] opt;
    logic [5:0] ln_r;
    logic [2:0] nl;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Own copy of the code, so a stale device copy is caught
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            cfg_r <= 8'h00;
        else if (!reset_n)
            cfg_r <= 8'h00;
        else if (cfg_wr && cs_n)
            cfg_r <= cfg_out_ctrl;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_r   <= 5'h00;
            rise_r <= 5'h00;
            ln_r   <= 6'h00;
        end else begin
            hi_r   <= ready_clock_out ? hi_r + 5'h01 : 5'h00;
            rise_r <= cs_n ? 5'h00 : rise_r + 5'($rose(ready_clock_out));
            // Launch edges so far; falls count only at double rate
            ln_r   <= cs_n ? 6'h00 : ln_r + 6'($rose(ready_clock_out) || (cfg_r[4] && $fell(ready_clock_out)));
        end
    end
    assign half = (cfg_r[7:6] == 2'h1) ? 5'h01 : (cfg_r[7:6] == 2'h2) ? 5'h02 : 5'h04;
    assign opt  = (cfg_r[3:2] == 2'h3) ? (cfg_r[4] ? 5'h03 : 5'h05)
                : (cfg_r[3] && cfg_r[4]) ? 5'h05 : 5'h09;
    assign nl   = (cfg_r[3:2] == 2'h3) ? 3'h4 : (cfg_r[3:2] == 2'h2) ? 3'h2 : 3'h1;
    idle_output_a: assert property (cs_n && $past(cs_n)
        |-> !ready_clock_out && serial_out_lane == 4'h0) else $error("output active outside frame");
    narrow_lanes_a: assert property (!cs_n && cfg_r[3:2] != 2'h3 |-> serial_out_lane[3:2] == 2'h0)
        else $error("upper lanes driven");
    single_lane_a: assert property (!cs_n && !cfg_r[3] |-> !serial_out_lane[1])
        else $error("lane one driven in single mode");
    sdr_launch_a: assert property (!$stable(serial_out_lane) && !cs_n && !$past(cs_n) && !cfg_r[4]
        |-> $rose(ready_clock_out)) else $error("sdr launch off rising edge");
    ddr_launch_a: assert property (!$stable(serial_out_lane) && !cs_n && !$past(cs_n) && cfg_r[4]
        |-> !$stable(ready_clock_out)) else $error("ddr launch off clock edge");
    ext_follow_a: assert property ($rose(sclk) && !cs_n && cfg_r[7:6] == 2'h0
        |-> ##[1:3] $rose(ready_clock_out)) else $error("output clock not following sclk");
    int_period_a: assert property ($fell(ready_clock_out) && !cs_n && cfg_r[7:6] != 2'h0
        |-> hi_r == half) else $error("internal clock half period wrong");
    frame_length_a: assert property ($rose(cs_n) |-> rise_r >= opt)
        else $error("frame shorter than optimal");
    dev_reset_a: assert property (!reset_n |-> !ready_clock_out && serial_out_lane == 4'h0)
        else $error("outputs active in device reset");
    // Launches past the word carry only zeros
    zero_fill_a: assert property (!cs_n && 9'(ln_r) * 9'(nl) >= 9'h016
        && ($rose(ready_clock_out) || (cfg_r[4] && $fell(ready_clock_out))) |-> serial_out_lane == 4'h0)
        else $error("data word not followed by zeros");
endmodule // ssop_link_properties

/* tb/source_sync_output_port_bench.sv */
`timescale 1ns/100ps
`include "ssop_defines.svh"
module source_sync_output_port_bench;
    logic        hclk = 1'b0;
    logic        hresetn;
    logic        hwrite;
    logic        hready;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [21:0] sample_data;
    logic [7:0]  output_control, input_protocol, code;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cyc = 0;
    ssop_link_if link ();
    ssop_host #(.CONV_CYCLES(2)) u_ssop_host (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
        .hresp(), .hrdata(hrdata), .link(link));
    ssop_device u_ssop_device (.hclk(hclk), .hresetn(hresetn), .link(link), .sample_data(sample_data),
        .sample_taken(), .frame_active(), .output_control(output_control), .input_protocol(input_protocol));
    ssop_link_properties u_ssop_link_properties (.hclk(hclk), .hresetn(hresetn), .cs_n(link.cs_n),
        .sclk(link.sclk), .reset_n(link.reset_n), .cfg_wr(link.cfg_wr), .cfg_out_ctrl(link.cfg_out_ctrl),
        .ready_clock_out(link.ready_clock_out), .serial_out_lane(link.serial_out_lane));
    always #20 hclk = ~hclk;
    // Slowest frame is a few hundred cycles; this leaves wide margin
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        q = hrdata;
    endtask
    task automatic wait_stat(input int b, input logic v);
        do bus(1'b0, `SSOP_A_STAT, 32'h0); while (q[b] !== v);
    endtask
    initial begin
        {hresetn, hwrite, htrans, haddr, hwdata} = '0;
        sample_data = 22'h3C5A96;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, `SSOP_A_DIV, 32'h0);
        chk(q, {24'h0, `SSOP_DIV_RST}, "divider reset");
        for (int i = 0; i < 24; i++) begin
            code = {i[1:0], 1'b0, i[2], (i < 8) ? 2'h0 : (i < 16) ? 2'h2 : 2'h3, 2'h3};
            sample_data <= 22'h2D3A5B ^ (22'(i) * 22'h0001F3);
            bus(1'b1, `SSOP_A_DEVCFG, {22'h0, i[3:2], code});
            wait_stat(3, 1'b0);
            chk({24'h0, output_control}, {24'h0, code}, "code");
            chk({24'h0, input_protocol}, {30'h0, i[3:2]}, "protocol");
            bus(1'b1, `SSOP_A_CTRL, 32'h1);
            wait_stat(1, 1'b0);
            bus(1'b0, `SSOP_A_DATA, 32'h0);
            chk(q, {10'h0, sample_data}, "word");
            $display("test code %h done", code);
        end
        // Device reset must drop the code; the host copy then needs resending
        bus(1'b1, `SSOP_A_CTRL, 32'h4);
        bus(1'b1, `SSOP_A_CTRL, 32'h0);
        chk({24'h0, output_control}, {24'h0, `SSOP_CFG_RST}, "reset code");
        bus(1'b1, `SSOP_A_DEVCFG, {24'h0, code});
        wait_stat(3, 1'b0);
        // Continuous mode must stall at full, not overwrite
        bus(1'b1, `SSOP_A_CTRL, 32'h2);
        wait_stat(2, 1'b1);
        bus(1'b1, `SSOP_A_CTRL, 32'h0);
        bus(1'b0, `SSOP_A_STAT, 32'h0);
        chk({24'h0, q[15:8]}, 32'h20, "fill count");
        for (int i = 0; i < 32; i++) begin
            bus(1'b0, `SSOP_A_DATA, 32'h0);
            chk(q, {10'h0, sample_data}, "queued word");
        end
        bus(1'b0, `SSOP_A_DATA, 32'h0);
        chk(q, 32'h0, "empty pop");
        bus(1'b1, 8'h1C, 32'hFFFFFFFF);
        bus(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0, "unmapped");
        $display("test fifo done");
        summarize();
    end
endmodule // source_sync_output_port_bench
